// ===== include/mbb_pkg.sv
package mbb_pkg;

  // opcode encodings
  localparam logic [7:0] OPC_MOV_DIR_IMM = 8'h75;
  localparam logic [7:0] OPC_MOV_IND_ACC = 8'hf6;
  localparam logic [7:0] OPC_MOV_IND_DIR = 8'ha6;
  localparam logic [7:0] OPC_MOV_IND_IMM = 8'h76;
  localparam logic [7:0] OPC_LOAD_DP = 8'h90;
  localparam logic [7:0] OPC_CODE_DP = 8'h93;
  localparam logic [7:0] OPC_CODE_PC = 8'h83;
  localparam logic [7:0] OPC_XREAD_PTR = 8'he2;
  localparam logic [7:0] OPC_XREAD_DP = 8'he0;
  localparam logic [7:0] OPC_XWRITE_PTR = 8'hf2;
  localparam logic [7:0] OPC_XWRITE_DP = 8'hf0;
  localparam logic [7:0] OPC_PUSH = 8'hc0;
  localparam logic [7:0] OPC_POP = 8'hd0;
  localparam logic [7:0] OPC_XCH_REG = 8'hc8;
  localparam logic [7:0] OPC_XCH_DIR = 8'hc5;
  localparam logic [7:0] OPC_XCH_IND = 8'hc6;
  localparam logic [7:0] OPC_LOW_NIBBLE_EXCHANGE_IND = 8'hd6;
  localparam logic [7:0] OPC_JMP_IND = 8'h73;
  localparam logic [7:0] OPC_BR_ZERO = 8'h60;
  localparam logic [7:0] OPC_BR_NONZERO = 8'h70;
  localparam logic [7:0] OPC_BR_CARRY = 8'h40;
  localparam logic [7:0] OPC_BR_NOCARRY = 8'h50;
  localparam logic [7:0] OPC_BR_BIT = 8'h20;
  localparam logic [7:0] OPC_BR_NOBIT = 8'h30;
  localparam logic [7:0] OPC_BR_BIT_CLR = 8'h10;
  localparam logic [7:0] OPC_CMP_ACC_IMM = 8'hb4;
  localparam logic [7:0] OPC_CMP_REG_IMM = 8'hb8;
  localparam logic [7:0] OPC_CMP_ACC_DIR = 8'hb5;
  localparam logic [7:0] OPC_CMP_IND_IMM = 8'hb6;
  localparam logic [7:0] OPC_DEC_REG = 8'hd8;
  localparam logic [7:0] OPC_DEC_DIR = 8'hd5;
  localparam logic [7:0] OPC_BIT_CLR = 8'hc2;
  localparam logic [7:0] OPC_BIT_SET = 8'hd2;
  localparam logic [7:0] OPC_BIT_CPL = 8'hb2;
  localparam logic [7:0] OPC_CARRY_CLR = 8'hc3;
  localparam logic [7:0] OPC_CARRY_SET = 8'hd3;
  localparam logic [7:0] OPC_CARRY_CPL = 8'hb3;
  localparam logic [7:0] OPC_AND_BIT = 8'h82;
  localparam logic [7:0] OPC_AND_NBIT = 8'hb0;
  localparam logic [7:0] OPC_OR_BIT = 8'h72;
  localparam logic [7:0] OPC_OR_NBIT = 8'ha0;
  localparam logic [7:0] OPC_CARRY_FROM_BIT = 8'ha2;
  localparam logic [7:0] OPC_BIT_FROM_CARRY = 8'h92;

  // masks for exact opcodes and for opcode groups that carry a register index in the low bits
  localparam logic [7:0] MASK_EXACT = 8'hff;
  localparam logic [7:0] MASK_PTR = 8'hfe;
  localparam logic [7:0] MASK_REG = 8'hf8;

  localparam logic [1:0] LEN1 = 2'h1;
  localparam logic [1:0] LEN2 = 2'h2;
  localparam logic [1:0] LEN3 = 2'h3;
  localparam logic [3:0] CYC1 = 4'h1;
  localparam logic [3:0] CYC2 = 4'h2;
  localparam logic [3:0] CYC3 = 4'h3;
  localparam logic [3:0] CYC4 = 4'h4;
  localparam logic [3:0] CYC5 = 4'h5;
  localparam logic [3:0] XREAD_BASE = 4'h3;
  localparam logic [3:0] XWRITE_BASE = 4'h4;

  typedef enum logic [5:0] {
    OP_NONE, OP_MOV_DIR_IMM, OP_MOV_IND_ACC, OP_MOV_IND_DIR, OP_MOV_IND_IMM,
    OP_LOAD_DP, OP_CODE_LOAD, OP_XREAD, OP_XWRITE, OP_PUSH, OP_POP, OP_XCH,
    OP_LOW_NIBBLE_EXCHANGE, OP_JMP_IND, OP_BR_ZERO, OP_BR_NONZERO, OP_BR_CARRY, OP_BR_NOCARRY,
    OP_BR_BIT, OP_BR_NOBIT, OP_BR_BIT_CLR, OP_CMP_JUMP, OP_DEC_JUMP, OP_BIT_CLR,
    OP_BIT_SET, OP_BIT_CPL, OP_CARRY_CLR, OP_CARRY_SET, OP_CARRY_CPL,
    OP_CARRY_AND, OP_CARRY_OR, OP_CARRY_FROM_BIT, OP_BIT_FROM_CARRY
  } op_t;

  typedef struct packed {
    logic acc_zero;
    logic carry;
    logic bit_val;
    logic operand_ne;
    logic dec_nonzero;
  } cond_t;

  typedef struct packed {
    op_t op;
    logic known;
    logic [1:0] len;
    logic [3:0] cycles;
    logic [2:0] reg_sel;
    logic wide_addr;
    logic code_space;
    logic taken;
    logic carry_wr;
    logic new_carry;
    logic bit_wr;
    logic new_bit;
  } dec_t;

  typedef struct packed {
    logic busy;
    logic [3:0] count;
    dec_t dec;
  } state_t;

endpackage

// ===== src/mbb_decoder.sv
`timescale 1ns/1ps
module mbb_decoder (
  input wire logic REF_CLK_I,
  input wire logic RSTN_I,
  input wire logic OPC_VALID_I,
  input wire logic [7:0] OPCODE_I,
  input wire mbb_pkg::cond_t COND_I,
  input wire logic PMW_I,
  input wire logic [2:0] XSTRETCH_I,
  output logic READY_O,
  output logic BUSY_O,
  output logic DONE_O,
  output mbb_pkg::dec_t DEC_O
);

  mbb_pkg::state_t state;
  mbb_pkg::state_t next_state;
  logic accept;

  function automatic logic in_group(input logic [7:0] opc, input logic [7:0] base,
                                    input logic [7:0] mask);
    in_group = (opc & mask) == base;
  endfunction

  function automatic mbb_pkg::dec_t set_timing(input mbb_pkg::dec_t d, input mbb_pkg::op_t op,
                                               input logic [1:0] len, input logic [3:0] cyc);
    mbb_pkg::dec_t r;
    r = d;
    r.op = op;
    r.known = 1'b1;
    r.len = len;
    r.cycles = cyc;
    set_timing = r;
  endfunction

  function automatic mbb_pkg::dec_t decode(input logic [7:0] opc, input mbb_pkg::cond_t c,
                                           input logic pmw, input logic [2:0] stretch);
    mbb_pkg::dec_t d;
    d = '0;
    d.op = mbb_pkg::OP_NONE;
    d.len = mbb_pkg::LEN1;
    d.cycles = mbb_pkg::CYC1;
    d.reg_sel = opc[2:0];
    if (in_group(opc, mbb_pkg::OPC_MOV_DIR_IMM, mbb_pkg::MASK_EXACT)) begin
      d = set_timing(d, mbb_pkg::OP_MOV_DIR_IMM, mbb_pkg::LEN3, mbb_pkg::CYC3);
    end else if (in_group(opc, mbb_pkg::OPC_MOV_IND_ACC, mbb_pkg::MASK_PTR)) begin
      d = set_timing(d, mbb_pkg::OP_MOV_IND_ACC, mbb_pkg::LEN1, mbb_pkg::CYC3);
    end else if (in_group(opc, mbb_pkg::OPC_MOV_IND_IMM, mbb_pkg::MASK_PTR)) begin
      d = set_timing(d, mbb_pkg::OP_MOV_IND_IMM, mbb_pkg::LEN2, mbb_pkg::CYC3);
    end else if (in_group(opc, mbb_pkg::OPC_MOV_IND_DIR, mbb_pkg::MASK_PTR)) begin
      d = set_timing(d, mbb_pkg::OP_MOV_IND_DIR, mbb_pkg::LEN2, mbb_pkg::CYC5);
    end else if (in_group(opc, mbb_pkg::OPC_LOAD_DP, mbb_pkg::MASK_EXACT)) begin
      d = set_timing(d, mbb_pkg::OP_LOAD_DP, mbb_pkg::LEN3, mbb_pkg::CYC3);
      d.wide_addr = 1'b1;
    end else if (in_group(opc, mbb_pkg::OPC_CODE_DP, mbb_pkg::MASK_EXACT)) begin
      d = set_timing(d, mbb_pkg::OP_CODE_LOAD, mbb_pkg::LEN1, mbb_pkg::CYC3);
      d.wide_addr = 1'b1;
    end else if (in_group(opc, mbb_pkg::OPC_CODE_PC, mbb_pkg::MASK_EXACT)) begin
      // wide_addr low means the program counter is the base, not the pointer
      d = set_timing(d, mbb_pkg::OP_CODE_LOAD, mbb_pkg::LEN1, mbb_pkg::CYC3);
    end else if (in_group(opc, mbb_pkg::OPC_XREAD_PTR, mbb_pkg::MASK_PTR) ||
                 in_group(opc, mbb_pkg::OPC_XREAD_DP, mbb_pkg::MASK_EXACT)) begin
      // stretch is three bits, so the count stays within 3..10
      d = set_timing(d, mbb_pkg::OP_XREAD, mbb_pkg::LEN1,
                     mbb_pkg::XREAD_BASE + {1'b0, stretch});
      d.wide_addr = ~opc[1];
      d.code_space = pmw;
    end else if (in_group(opc, mbb_pkg::OPC_XWRITE_PTR, mbb_pkg::MASK_PTR) ||
                 in_group(opc, mbb_pkg::OPC_XWRITE_DP, mbb_pkg::MASK_EXACT)) begin
      d = set_timing(d, mbb_pkg::OP_XWRITE, mbb_pkg::LEN1,
                     mbb_pkg::XWRITE_BASE + {1'b0, stretch});
      d.wide_addr = ~opc[1];
      d.code_space = pmw;
    end else if (in_group(opc, mbb_pkg::OPC_PUSH, mbb_pkg::MASK_EXACT)) begin
      d = set_timing(d, mbb_pkg::OP_PUSH, mbb_pkg::LEN2, mbb_pkg::CYC4);
    end else if (in_group(opc, mbb_pkg::OPC_POP, mbb_pkg::MASK_EXACT)) begin
      d = set_timing(d, mbb_pkg::OP_POP, mbb_pkg::LEN2, mbb_pkg::CYC3);
    end else if (in_group(opc, mbb_pkg::OPC_XCH_REG, mbb_pkg::MASK_REG)) begin
      d = set_timing(d, mbb_pkg::OP_XCH, mbb_pkg::LEN1, mbb_pkg::CYC2);
    end else if (in_group(opc, mbb_pkg::OPC_XCH_DIR, mbb_pkg::MASK_EXACT)) begin
      d = set_timing(d, mbb_pkg::OP_XCH, mbb_pkg::LEN2, mbb_pkg::CYC3);
    end else if (in_group(opc, mbb_pkg::OPC_XCH_IND, mbb_pkg::MASK_PTR)) begin
      d = set_timing(d, mbb_pkg::OP_XCH, mbb_pkg::LEN1, mbb_pkg::CYC3);
    end else if (in_group(opc, mbb_pkg::OPC_LOW_NIBBLE_EXCHANGE_IND, mbb_pkg::MASK_PTR)) begin
      d = set_timing(d, mbb_pkg::OP_LOW_NIBBLE_EXCHANGE, mbb_pkg::LEN1, mbb_pkg::CYC3);
    end else if (in_group(opc, mbb_pkg::OPC_JMP_IND, mbb_pkg::MASK_EXACT)) begin
      d = set_timing(d, mbb_pkg::OP_JMP_IND, mbb_pkg::LEN1, mbb_pkg::CYC2);
      d.wide_addr = 1'b1;
      d.taken = 1'b1;
    end else if (in_group(opc, mbb_pkg::OPC_BR_ZERO, mbb_pkg::MASK_EXACT)) begin
      d = set_timing(d, mbb_pkg::OP_BR_ZERO, mbb_pkg::LEN2, mbb_pkg::CYC3);
      d.taken = c.acc_zero;
    end else if (in_group(opc, mbb_pkg::OPC_BR_NONZERO, mbb_pkg::MASK_EXACT)) begin
      d = set_timing(d, mbb_pkg::OP_BR_NONZERO, mbb_pkg::LEN2, mbb_pkg::CYC3);
      d.taken = ~c.acc_zero;
    end else if (in_group(opc, mbb_pkg::OPC_BR_CARRY, mbb_pkg::MASK_EXACT)) begin
      d = set_timing(d, mbb_pkg::OP_BR_CARRY, mbb_pkg::LEN2, mbb_pkg::CYC3);
      d.taken = c.carry;
    end else if (in_group(opc, mbb_pkg::OPC_BR_NOCARRY, mbb_pkg::MASK_EXACT)) begin
      d = set_timing(d, mbb_pkg::OP_BR_NOCARRY, mbb_pkg::LEN2, mbb_pkg::CYC3);
      d.taken = ~c.carry;
    end else if (in_group(opc, mbb_pkg::OPC_BR_BIT, mbb_pkg::MASK_EXACT)) begin
      d = set_timing(d, mbb_pkg::OP_BR_BIT, mbb_pkg::LEN3, mbb_pkg::CYC4);
      d.taken = c.bit_val;
    end else if (in_group(opc, mbb_pkg::OPC_BR_NOBIT, mbb_pkg::MASK_EXACT)) begin
      d = set_timing(d, mbb_pkg::OP_BR_NOBIT, mbb_pkg::LEN3, mbb_pkg::CYC4);
      d.taken = ~c.bit_val;
    end else if (in_group(opc, mbb_pkg::OPC_BR_BIT_CLR, mbb_pkg::MASK_EXACT)) begin
      // the bit is only rewritten when the branch is taken
      d = set_timing(d, mbb_pkg::OP_BR_BIT_CLR, mbb_pkg::LEN3, mbb_pkg::CYC4);
      d.taken = c.bit_val;
      d.bit_wr = c.bit_val;
      d.new_bit = 1'b0;
    end else if (in_group(opc, mbb_pkg::OPC_CMP_ACC_IMM, mbb_pkg::MASK_EXACT) ||
                 in_group(opc, mbb_pkg::OPC_CMP_REG_IMM, mbb_pkg::MASK_REG)) begin
      d = set_timing(d, mbb_pkg::OP_CMP_JUMP, mbb_pkg::LEN3, mbb_pkg::CYC4);
      d.taken = c.operand_ne;
    end else if (in_group(opc, mbb_pkg::OPC_CMP_ACC_DIR, mbb_pkg::MASK_EXACT) ||
                 in_group(opc, mbb_pkg::OPC_CMP_IND_IMM, mbb_pkg::MASK_PTR)) begin
      d = set_timing(d, mbb_pkg::OP_CMP_JUMP, mbb_pkg::LEN3, mbb_pkg::CYC4);
      d.taken = c.operand_ne;
    end else if (in_group(opc, mbb_pkg::OPC_DEC_REG, mbb_pkg::MASK_REG)) begin
      d = set_timing(d, mbb_pkg::OP_DEC_JUMP, mbb_pkg::LEN2, mbb_pkg::CYC3);
      d.taken = c.dec_nonzero;
    end else if (in_group(opc, mbb_pkg::OPC_DEC_DIR, mbb_pkg::MASK_EXACT)) begin
      d = set_timing(d, mbb_pkg::OP_DEC_JUMP, mbb_pkg::LEN3, mbb_pkg::CYC4);
      d.taken = c.dec_nonzero;
    end else if (in_group(opc, mbb_pkg::OPC_BIT_CLR, mbb_pkg::MASK_EXACT)) begin
      d = set_timing(d, mbb_pkg::OP_BIT_CLR, mbb_pkg::LEN2, mbb_pkg::CYC3);
      d.bit_wr = 1'b1;
      d.new_bit = 1'b0;
    end else if (in_group(opc, mbb_pkg::OPC_BIT_SET, mbb_pkg::MASK_EXACT)) begin
      d = set_timing(d, mbb_pkg::OP_BIT_SET, mbb_pkg::LEN2, mbb_pkg::CYC3);
      d.bit_wr = 1'b1;
      d.new_bit = 1'b1;
    end else if (in_group(opc, mbb_pkg::OPC_BIT_CPL, mbb_pkg::MASK_EXACT)) begin
      d = set_timing(d, mbb_pkg::OP_BIT_CPL, mbb_pkg::LEN2, mbb_pkg::CYC3);
      d.bit_wr = 1'b1;
      d.new_bit = ~c.bit_val;
    end else if (in_group(opc, mbb_pkg::OPC_CARRY_CLR, mbb_pkg::MASK_EXACT)) begin
      d = set_timing(d, mbb_pkg::OP_CARRY_CLR, mbb_pkg::LEN1, mbb_pkg::CYC1);
      d.carry_wr = 1'b1;
      d.new_carry = 1'b0;
    end else if (in_group(opc, mbb_pkg::OPC_CARRY_SET, mbb_pkg::MASK_EXACT)) begin
      d = set_timing(d, mbb_pkg::OP_CARRY_SET, mbb_pkg::LEN1, mbb_pkg::CYC1);
      d.carry_wr = 1'b1;
      d.new_carry = 1'b1;
    end else if (in_group(opc, mbb_pkg::OPC_CARRY_CPL, mbb_pkg::MASK_EXACT)) begin
      d = set_timing(d, mbb_pkg::OP_CARRY_CPL, mbb_pkg::LEN1, mbb_pkg::CYC1);
      d.carry_wr = 1'b1;
      d.new_carry = ~c.carry;
    end else if (in_group(opc, mbb_pkg::OPC_AND_BIT, mbb_pkg::MASK_EXACT) ||
                 in_group(opc, mbb_pkg::OPC_AND_NBIT, mbb_pkg::MASK_EXACT)) begin
      d = set_timing(d, mbb_pkg::OP_CARRY_AND, mbb_pkg::LEN2, mbb_pkg::CYC2);
      d.carry_wr = 1'b1;
      d.new_carry = c.carry & (c.bit_val ^ opc[5]);
    end else if (in_group(opc, mbb_pkg::OPC_OR_BIT, mbb_pkg::MASK_EXACT) ||
                 in_group(opc, mbb_pkg::OPC_OR_NBIT, mbb_pkg::MASK_EXACT)) begin
      // bit 7 tells the complemented form apart from the plain one
      d = set_timing(d, mbb_pkg::OP_CARRY_OR, mbb_pkg::LEN2, mbb_pkg::CYC2);
      d.carry_wr = 1'b1;
      d.new_carry = c.carry | (c.bit_val ^ opc[7]);
    end else if (in_group(opc, mbb_pkg::OPC_CARRY_FROM_BIT, mbb_pkg::MASK_EXACT)) begin
      d = set_timing(d, mbb_pkg::OP_CARRY_FROM_BIT, mbb_pkg::LEN2, mbb_pkg::CYC2);
      d.carry_wr = 1'b1;
      d.new_carry = c.bit_val;
    end else if (in_group(opc, mbb_pkg::OPC_BIT_FROM_CARRY, mbb_pkg::MASK_EXACT)) begin
      d = set_timing(d, mbb_pkg::OP_BIT_FROM_CARRY, mbb_pkg::LEN2, mbb_pkg::CYC3);
      d.bit_wr = 1'b1;
      d.new_bit = c.carry;
    end
    decode = d;
  endfunction

  // last cycle of the running instruction frees the decoder for back to back issue
  assign DONE_O = state.busy && (state.count == mbb_pkg::CYC1);
  assign READY_O = !state.busy || DONE_O;
  assign accept = OPC_VALID_I && READY_O;
  assign BUSY_O = state.busy;
  assign DEC_O = state.dec;

  always_comb begin
    next_state = state;
    if (accept) begin
      next_state.dec = decode(OPCODE_I, COND_I, PMW_I, XSTRETCH_I);
      next_state.count = next_state.dec.cycles;
      next_state.busy = 1'b1;
    end else if (DONE_O) begin
      next_state.busy = 1'b0;
      next_state.count = '0;
    end else if (state.busy) begin
      next_state.count = state.count - mbb_pkg::CYC1;
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (!RSTN_I) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  a_dir_imm_timing: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
    accept && OPCODE_I == 8'h75 |=> DEC_O.len == 2'h3 && DEC_O.cycles == 4'h3
      && !DONE_O ##1 !DONE_O ##1 DONE_O)
    else $error("direct immediate store timing wrong");

  a_ind_store_len: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
    accept && OPCODE_I[7:1] == 7'h3b |=> DEC_O.len == 2'h2 && DEC_O.op == mbb_pkg::OP_MOV_IND_IMM)
    else $error("indirect immediate store decoded wrong");

  a_ind_dir_five: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
    accept && OPCODE_I[7:1] == 7'h53 |=> !DONE_O [*4] ##1 DONE_O)
    else $error("direct to indirect copy not five cycles");

  a_xread_range: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
    accept && OPCODE_I == 8'he0 |=> DEC_O.cycles == 4'h3 + {1'b0, $past(XSTRETCH_I)}
      && DEC_O.wide_addr)
    else $error("external read cycle count wrong");

  a_xwrite_mode: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
    accept && OPCODE_I[7:1] == 7'h79 |=> DEC_O.code_space == $past(PMW_I)
      && DEC_O.cycles == 4'h4 + {1'b0, $past(XSTRETCH_I)} && !DEC_O.wide_addr)
    else $error("external write mode or timing wrong");

  a_push_four: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
    accept && OPCODE_I == 8'hc0 |=> !DONE_O [*3] ##1 DONE_O ##0 READY_O)
    else $error("push not four cycles");

  a_bit_clear_branch: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
    accept && OPCODE_I == 8'h10 |=> DEC_O.taken == DEC_O.bit_wr && !DEC_O.new_bit
      && DEC_O.taken == $past(COND_I.bit_val))
    else $error("bit test and clear wrong");

  a_dec_reg_short: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
    accept && OPCODE_I[7:3] == 5'h1b |=> DEC_O.len == 2'h2 && DEC_O.cycles == 4'h3
      && DEC_O.taken == $past(COND_I.dec_nonzero))
    else $error("register decrement branch wrong");

  a_carry_single: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
    accept && OPCODE_I == 8'hb3 |=> DONE_O && DEC_O.new_carry == !$past(COND_I.carry))
    else $error("carry complement wrong");

  a_and_not_bit: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
    accept && OPCODE_I == 8'hb0 |=> DEC_O.carry_wr
      && DEC_O.new_carry == ($past(COND_I.carry) && !$past(COND_I.bit_val)))
    else $error("carry and complement wrong");

  a_or_not_bit: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
    accept && OPCODE_I == 8'ha0 |=> !DONE_O ##1 DONE_O
      && DEC_O.new_carry == ($past(COND_I.carry, 2) || !$past(COND_I.bit_val, 2)))
    else $error("carry or complement wrong");

  a_load_ptr_wide: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
    accept && OPCODE_I == 8'h90 |=> DEC_O.len == 2'h3 && DEC_O.wide_addr
      && !DONE_O ##1 !DONE_O ##1 DONE_O)
    else $error("data pointer load wrong");

  a_code_load_base: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
    accept && (OPCODE_I == 8'h93 || OPCODE_I == 8'h83) |=> DEC_O.len == 2'h1
      && DEC_O.cycles == 4'h3 && DEC_O.wide_addr == $past(OPCODE_I[4]))
    else $error("code byte load wrong");

  a_xwrite_wide: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
    accept && OPCODE_I == 8'hf0 |=> DEC_O.op == mbb_pkg::OP_XWRITE && DEC_O.wide_addr
      && DEC_O.cycles == 4'h4 + {1'b0, $past(XSTRETCH_I)})
    else $error("pointer external write wrong");

  a_exchange_reg: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
    accept && OPCODE_I[7:3] == 5'h19 |=> DEC_O.op == mbb_pkg::OP_XCH && DEC_O.len == 2'h1
      && DEC_O.reg_sel == $past(OPCODE_I[2:0]) ##0 !DONE_O ##1 DONE_O)
    else $error("register exchange wrong");

  a_nibble_swap: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
    accept && OPCODE_I[7:1] == 7'h6b |=> DEC_O.op == mbb_pkg::OP_LOW_NIBBLE_EXCHANGE && DEC_O.len == 2'h1
      && DEC_O.cycles == 4'h3)
    else $error("nibble exchange wrong");

  a_jump_indirect: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
    accept && OPCODE_I == 8'h73 |=> DEC_O.taken && DEC_O.wide_addr && DEC_O.len == 2'h1
      ##0 !DONE_O ##1 DONE_O)
    else $error("indirect jump wrong");

  a_acc_branch: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
    accept && OPCODE_I == 8'h70 |=> DEC_O.taken == !$past(COND_I.acc_zero)
      && DEC_O.len == 2'h2 && DEC_O.cycles == 4'h3)
    else $error("accumulator branch wrong");

  a_carry_branch: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
    accept && OPCODE_I == 8'h50 |=> DEC_O.taken == !$past(COND_I.carry)
      && DEC_O.len == 2'h2 && DEC_O.cycles == 4'h3)
    else $error("carry branch wrong");

  a_cmp_reg_branch: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
    accept && OPCODE_I[7:3] == 5'h17 |=> DEC_O.op == mbb_pkg::OP_CMP_JUMP
      && DEC_O.taken == $past(COND_I.operand_ne) ##0 !DONE_O [*3] ##1 DONE_O)
    else $error("register compare branch wrong");

  a_cmp_ind_branch: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
    accept && OPCODE_I[7:1] == 7'h5b |=> DEC_O.len == 2'h3 && DEC_O.cycles == 4'h4
      && DEC_O.taken == $past(COND_I.operand_ne))
    else $error("indirect compare branch wrong");

  a_carry_to_bit: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
    accept && OPCODE_I == 8'h92 |=> DEC_O.bit_wr && !DEC_O.carry_wr
      && DEC_O.new_bit == $past(COND_I.carry) ##0 !DONE_O [*2] ##1 DONE_O)
    else $error("carry to bit move wrong");

  c_back_to_back: cover property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
    DONE_O && OPC_VALID_I ##1 BUSY_O);
  c_long_xread: cover property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
    BUSY_O && DEC_O.op == mbb_pkg::OP_XREAD && DEC_O.cycles == 4'ha);
  c_branch_taken: cover property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
    DONE_O && DEC_O.op == mbb_pkg::OP_CMP_JUMP && DEC_O.taken);
  c_code_space_write: cover property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
    DONE_O && DEC_O.op == mbb_pkg::OP_XWRITE && DEC_O.code_space);

endmodule

// ===== tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic opc_valid = 1'b0;
  logic [7:0] opcode = 8'h00;
  mbb_pkg::cond_t cond = '0;
  logic pmw = 1'b0;
  logic [2:0] xstretch = 3'h0;
  logic ready;
  logic busy;
  logic done;
  mbb_pkg::dec_t dec;
  int err_total = 0;
  int num_checks = 0;
  // listed codes first, then two codes from outside the group
  logic [7:0] ops [$] = '{8'h75, 8'hf6, 8'hf7, 8'h76, 8'h77, 8'ha6, 8'ha7, 8'h90, 8'h93,
    8'h83, 8'he2, 8'he3, 8'he0, 8'hf2, 8'hf3, 8'hf0, 8'hc0, 8'hd0, 8'hc8, 8'hcf, 8'hc5,
    8'hc6, 8'hc7, 8'hd6, 8'hd7, 8'h73, 8'h60, 8'h70, 8'h40, 8'h50, 8'h20, 8'h30, 8'h10,
    8'hb4, 8'hb8, 8'hbf, 8'hb5, 8'hb6, 8'hb7, 8'hd8, 8'hdf, 8'hd5, 8'hc2, 8'hd2, 8'hb2,
    8'hc3, 8'hd3, 8'hb3, 8'h82, 8'hb0, 8'h72, 8'ha0, 8'ha2, 8'h92, 8'h00, 8'h24};

  always #2 ref_clk = ~ref_clk;

  mbb_decoder mbb_decoder_i (
    .REF_CLK_I(ref_clk),
    .RSTN_I(rstn),
    .OPC_VALID_I(opc_valid),
    .OPCODE_I(opcode),
    .COND_I(cond),
    .PMW_I(pmw),
    .XSTRETCH_I(xstretch),
    .READY_O(ready),
    .BUSY_O(busy),
    .DONE_O(done),
    .DEC_O(dec)
  );

  // returns {known, len, cycles}
  function automatic logic [6:0] timing(input logic [7:0] op, input logic [2:0] st);
    casez (op)
      8'h75, 8'h90: return {1'b1, 2'h3, 4'h3};
      8'b1111011?, 8'h93, 8'h83: return {1'b1, 2'h1, 4'h3};
      8'b0111011?, 8'hd0, 8'hc5: return {1'b1, 2'h2, 4'h3};
      8'b1010011?: return {1'b1, 2'h2, 4'h5};
      8'he0, 8'b1110001?: return {1'b1, 2'h1, 4'h3 + 4'(st)};
      8'hf0, 8'b1111001?: return {1'b1, 2'h1, 4'h4 + 4'(st)};
      8'hc0: return {1'b1, 2'h2, 4'h4};
      8'b11001???, 8'h73: return {1'b1, 2'h1, 4'h2};
      8'b1100011?, 8'b1101011?: return {1'b1, 2'h1, 4'h3};
      8'h60, 8'h70, 8'h40, 8'h50: return {1'b1, 2'h2, 4'h3};
      8'h20, 8'h30, 8'h10: return {1'b1, 2'h3, 4'h4};
      8'hb4, 8'hb5, 8'b1011011?, 8'b10111???: return {1'b1, 2'h3, 4'h4};
      8'b11011???, 8'hc2, 8'hd2, 8'hb2: return {1'b1, 2'h2, 4'h3};
      8'hd5: return {1'b1, 2'h3, 4'h4};
      8'hc3, 8'hd3, 8'hb3: return {1'b1, 2'h1, 4'h1};
      8'h82, 8'hb0, 8'h72, 8'ha0, 8'ha2: return {1'b1, 2'h2, 4'h2};
      8'h92: return {1'b1, 2'h2, 4'h3};
      default: return {1'b0, 2'h1, 4'h1};
    endcase
  endfunction

  // returns {applies, taken}
  function automatic logic [1:0] branch(input logic [7:0] op, input mbb_pkg::cond_t c);
    casez (op)
      8'h60: return {1'b1, c.acc_zero};
      8'h70: return {1'b1, !c.acc_zero};
      8'h40: return {1'b1, c.carry};
      8'h50: return {1'b1, !c.carry};
      8'h20, 8'h10: return {1'b1, c.bit_val};
      8'h30: return {1'b1, !c.bit_val};
      8'hb4, 8'hb5, 8'b1011011?, 8'b10111???: return {1'b1, c.operand_ne};
      8'hd5, 8'b11011???: return {1'b1, c.dec_nonzero};
      default: return 2'b00;
    endcase
  endfunction

  // returns {applies, carry_wr, new_carry, bit_wr, new_bit}
  function automatic logic [4:0] writes(input logic [7:0] op, input mbb_pkg::cond_t c);
    case (op)
      8'hc3: return 5'b11000;
      8'hd3: return 5'b11100;
      8'hb3: return {2'b11, !c.carry, 2'b00};
      8'hc2: return 5'b10010;
      8'hd2: return 5'b10011;
      8'hb2: return {4'b1001, !c.bit_val};
      8'h82: return {2'b11, c.carry & c.bit_val, 2'b00};
      8'hb0: return {2'b11, c.carry & !c.bit_val, 2'b00};
      8'h72: return {2'b11, c.carry | c.bit_val, 2'b00};
      8'ha0: return {2'b11, c.carry | !c.bit_val, 2'b00};
      8'ha2: return {2'b11, c.bit_val, 2'b00};
      8'h92: return {4'b1001, c.carry};
      8'h10: return {3'b100, c.bit_val, 1'b0};
      // every other code must leave carry and bit alone
      default: return 5'b10000;
    endcase
  endfunction

  task automatic chk_field(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_flag(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic offer(input logic [7:0] op, input logic vld, input logic [2:0] st);
    opc_valid <= vld;
    opcode <= op;
    cond <= mbb_pkg::cond_t'(5'($urandom));
    pmw <= 1'($urandom);
    xstretch <= st;
  endtask

  task automatic complete_run();
    $display("checks=%0d mismatches=%0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    logic [7:0] cur;
    logic [7:0] nxt;
    mbb_pkg::cond_t c;
    logic p;
    logic [2:0] s;
    logic [6:0] t;
    logic [1:0] br;
    logic [4:0] w;
    logic [3:0] fl;
    logic wd;
    int n;
    void'($urandom(39));
    repeat (4) @(posedge ref_clk);
    rstn <= 1'b1;
    #1;
    chk_flag(busy, 1'b0);
    chk_flag(ready, 1'b1);
    chk_flag(dec === '0, 1'b1);
    @(posedge ref_clk);
    offer(ops[0], 1'b1, 3'h0);
    @(posedge ref_clk);
    cur = opcode;
    c = cond;
    p = pmw;
    s = xstretch;
    // each next offer is held through the busy cycles, so refusal is exercised back to back
    for (int i = 1; i < 400; i++) begin
      if (i < ops.size()) begin
        nxt = ops[i];
      end else if ($urandom_range(3) == 0) begin
        nxt = 8'($urandom);
      end else begin
        nxt = ops[$urandom_range(ops.size() - 1)];
      end
      offer(nxt, 1'(i < 399), (i < ops.size()) ? {3{i[0]}} : 3'($urandom));
      t = timing(cur, s);
      br = branch(cur, c);
      w = writes(cur, c);
      n = int'(t[3:0]);
      #1;
      chk_field(8'(dec.len), 8'(t[5:4]));
      chk_field(8'(dec.cycles), 8'(t[3:0]));
      chk_flag(dec.known, t[6]);
      if (t[6]) chk_field(8'(dec.reg_sel), 8'(cur[2:0]));
      if (br[1]) chk_flag(dec.taken, br[0]);
      fl = {dec.carry_wr, dec.new_carry, dec.bit_wr, dec.new_bit};
      wd = cur inside {8'h90, 8'h93, 8'he0, 8'hf0, 8'h73};
      if (w[4]) chk_field(8'(fl), 8'(w[3:0]));
      chk_flag(dec.wide_addr, wd);
      if (cur[7:5] == 3'b111 && cur[3:2] == 2'b00 && cur[1:0] != 2'b01) begin
        chk_flag(dec.code_space, p);
      end
      for (int k = 1; k <= n; k++) begin
        chk_flag(done, 1'(k == n));
        chk_flag(ready, 1'(k == n));
        chk_flag(busy, 1'b1);
        @(posedge ref_clk);
        if (k < n) #1;
      end
      cur = opcode;
      c = cond;
      p = pmw;
      s = xstretch;
    end
    // a reset in the middle of a long transfer must abandon it at once
    offer(8'ha6, 1'b1, 3'h0);
    @(posedge ref_clk);
    opc_valid <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b0;
    @(posedge ref_clk);
    #1;
    chk_flag(busy, 1'b0);
    chk_flag(done, 1'b0);
    chk_flag(ready, 1'b1);
    // release again mid-run; the first offer after release must be taken at once
    rstn <= 1'b1;
    @(posedge ref_clk);
    offer(8'hc3, 1'b1, 3'h0);
    @(posedge ref_clk);
    opc_valid <= 1'b0;
    #1;
    chk_flag(done, 1'b1);
    chk_field(8'(dec.op), 8'(mbb_pkg::OP_CARRY_CLR));
    chk_flag(dec.carry_wr && !dec.new_carry, 1'b1);
    complete_run();
  end
endmodule
